// ---- src/bfd_pkg.sv ----
package bfd_pkg;

  localparam int FIFO_DEPTH = 64;
  localparam int CNT_W = 7;
  localparam int PTR_W = 6;
  localparam logic [7:0] EP1_FIFO_ADDR = 8'h40;

  localparam int CLK_MHZ = 25;
  // Longest request re-enable time, rounded down, at least one cycle
  localparam int REQ_ENABLE_NS = 63;
  localparam int REQ_ENABLE_RAW = (REQ_ENABLE_NS * CLK_MHZ) / 1000;
  localparam int REQ_ENABLE_CYC = (REQ_ENABLE_RAW < 1) ? 1 : REQ_ENABLE_RAW;
  // Extra cycles added per unit of the programmed request spacing
  localparam int SPACING_UNIT_CYC = 1;
  localparam int GAP_W = 12;

  localparam logic RESET_REQ_ACTIVE_HIGH = 1'b0;
  localparam logic RESET_ACK_ACTIVE_HIGH = 1'b1;

  typedef enum logic [1:0] {
    LINE_SE0,
    LINE_DIFF0,
    LINE_DIFF1,
    LINE_UNDEF
  } bfd_line_t;

  typedef struct packed {
    logic dma_enable;
    logic demand_mode;
    logic dual_address;
    logic wide_16;
    logic fifo_is_rx;
    logic req_active_high;
    logic ack_active_high;
    logic [7:0] dma_request_spacing;
    logic [CNT_W-1:0] payload_size;
  } bfd_ctrl_t;

  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic dma_acknowledge;
    logic [7:0] address_lines;
    logic [15:0] data;
  } bfd_bus_t;

  typedef struct packed {
    logic packet_ready;
    logic fifo_full;
    logic fifo_empty;
    logic [CNT_W-1:0] byte_count;
    bfd_line_t line_state;
  } bfd_status_t;

endpackage

// ---- src/bfd_byte_mem.sv ----
module bfd_byte_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic sys_clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Refuse sizes that the address width cannot reach
  if (DEPTH > (1 << AW) || WIDTH < 1) begin : g_bad_size
    $error("bfd_byte_mem: depth does not fit address width");
  end

  always_ff @(posedge sys_clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read keeps the data output free of memory decode glitches
  always_ff @(posedge sys_clk) begin
    if (ce && re) begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ---- src/bfd_dma_write_port.sv ----
// Summary of operation
// - Dual-address mode ignores acknowledge; write needs select and strobe.
// - Single-address mode ignores address and select; acknowledge and strobe.
// - Single mode re-request delay is lengthened by the spacing value.
// - Demand mode drops request at the write reaching the payload size.
// - Software packet-ready ends a partial fill as a complete packet.
// - Line pair decodes to SE0, differential zero, one, or undefined.
// - Single mode drops request after every completed transfer.
// - Only the bulk endpoint one FIFO takes part in DMA.
// - Request resets active low, acknowledge active high; both programmable.
module bfd_dma_write_port
  import bfd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input bfd_pkg::bfd_ctrl_t ctrl,
  input wire logic packet_ready_set,
  input bfd_pkg::bfd_bus_t bus,
  input wire logic usb_dp,
  input wire logic usb_dm,
  input wire logic tx_read,
  input wire logic packet_sent,
  output logic dma_request,
  output logic [7:0] tx_data,
  output bfd_pkg::bfd_status_t status
);

  import bfd_pkg::*;

  default clocking cb_sys @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQ,
    ST_RELEASE,
    ST_GAP
  } bfd_state_t;

  function automatic bfd_line_t line_decode(input logic dp, input logic dm);
    unique case ({dp, dm})
      2'b00: line_decode = LINE_SE0;
      2'b01: line_decode = LINE_DIFF0;
      2'b10: line_decode = LINE_DIFF1;
      default: line_decode = LINE_UNDEF;
    endcase
  endfunction

  bfd_bus_t bus_m_reg, bus_s_reg;
  logic [1:0] dp_m_reg, dm_m_reg;
  logic dp_s_reg, dm_s_reg;
  logic qual, qual_d_reg, wr_event, room, byte_we, hi_pend_reg;
  logic [7:0] hi_byte_reg, wbyte;
  logic [CNT_W-1:0] cnt_reg;
  logic [PTR_W-1:0] wptr_reg, rptr_reg;
  logic pkt_ready_reg, full, req_active, ack_on, cs_sel, final_byte;
  bfd_state_t state_reg, state_next;
  logic [GAP_W-1:0] gap_reg;
  bfd_line_t line_reg;

  // Pins are asynchronous to sys_clk: bus pins pass two flops, line pins three, before any use
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bus_m_reg <= '{cs_n: 1'b1, wr_n: 1'b1, default: '0};
      bus_s_reg <= '{cs_n: 1'b1, wr_n: 1'b1, default: '0};
      dp_m_reg <= 2'h0;
      dm_m_reg <= 2'h0;
      dp_s_reg <= 1'b0;
      dm_s_reg <= 1'b0;
    end else if (ce) begin
      bus_m_reg <= bus;
      bus_s_reg <= bus_m_reg;
      dp_m_reg <= {dp_m_reg[0], usb_dp};
      dm_m_reg <= {dm_m_reg[0], usb_dm};
      dp_s_reg <= dp_m_reg[1];
      dm_s_reg <= dm_m_reg[1];
    end
  end

  assign ack_on = bus_s_reg.dma_acknowledge == ctrl.ack_active_high;
  // only the endpoint one FIFO address selects in dual mode
  assign cs_sel = !bus_s_reg.cs_n && bus_s_reg.address_lines == EP1_FIFO_ADDR;
  // qualify by whichever select goes active last
  assign qual = ctrl.dma_enable && !ctrl.fifo_is_rx && !bus_s_reg.wr_n &&
                (ctrl.dual_address ? cs_sel : ack_on);
  assign wr_event = qual && !qual_d_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      qual_d_reg <= 1'b0;
    end else if (ce) begin
      qual_d_reg <= qual;
    end
  end

  assign full = cnt_reg == CNT_W'(FIFO_DEPTH);
  assign room = !full && !pkt_ready_reg && cnt_reg != ctrl.payload_size;
  // Upper byte of a 16-bit write lands one cycle after the lower byte
  assign byte_we = (wr_event && room && !hi_pend_reg) || hi_pend_reg;
  assign wbyte = hi_pend_reg ? hi_byte_reg : bus_s_reg.data[7:0];
  assign final_byte = byte_we && (cnt_reg + CNT_W'(1)) == ctrl.payload_size;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hi_pend_reg <= 1'b0;
      hi_byte_reg <= 8'h00;
    end else if (ce) begin
      hi_pend_reg <= wr_event && room && !hi_pend_reg && ctrl.wide_16 &&
                     !final_byte;
      hi_byte_reg <= bus_s_reg.data[15:8];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else if (ce) begin
      if (packet_sent) begin
        cnt_reg <= '0;
        wptr_reg <= '0;
        rptr_reg <= '0;
      end else begin
        if (byte_we) begin
          cnt_reg <= cnt_reg + CNT_W'(1);
          wptr_reg <= wptr_reg + PTR_W'(1);
        end
        if (tx_read) begin
          rptr_reg <= rptr_reg + PTR_W'(1);
        end
      end
    end
  end

  // packet complete at payload size or by software; set beats clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pkt_ready_reg <= 1'b0;
    end else if (ce) begin
      if (final_byte || packet_ready_set) begin
        pkt_ready_reg <= 1'b1;
      end else if (packet_sent) begin
        pkt_ready_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (ctrl.dma_enable && !ctrl.fifo_is_rx) begin
          state_next = ST_REQ;
        end
      end
      ST_REQ: begin
        if (!ctrl.dma_enable) begin
          state_next = ST_IDLE;
        end else if (wr_event && !ctrl.demand_mode) begin
          // single mode gives the bus back after each transfer
          state_next = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (!qual && !hi_pend_reg) begin
          state_next = ST_GAP;
        end
      end
      ST_GAP: begin
        if (gap_reg == '0) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // gap grows with the programmed spacing
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gap_reg <= '0;
    end else if (ce) begin
      if (state_reg == ST_RELEASE) begin
        gap_reg <= GAP_W'(REQ_ENABLE_CYC - 1) +
                   GAP_W'(ctrl.dma_request_spacing) * GAP_W'(SPACING_UNIT_CYC);
      end else if (gap_reg != '0) begin
        gap_reg <= gap_reg - GAP_W'(1);
      end
    end
  end

  // no request without space or in reception; none once packet done
  assign req_active = state_reg == ST_REQ && ctrl.dma_enable &&
                      !ctrl.fifo_is_rx && !full && !pkt_ready_reg &&
                      !hi_pend_reg;
  assign dma_request = ctrl.req_active_high ? req_active : !req_active;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      line_reg <= LINE_SE0;
    end else if (ce) begin
      line_reg <= line_decode(dp_s_reg, dm_s_reg);
    end
  end

  bfd_byte_mem #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(PTR_W)
  ) u_mem (
    .sys_clk(sys_clk),
    .ce(ce),
    .we(byte_we),
    .waddr(wptr_reg),
    .wdata(wbyte),
    .re(tx_read),
    .raddr(rptr_reg),
    .rdata(tx_data)
  );

  assign status = '{packet_ready: pkt_ready_reg, fifo_full: full,
                    fifo_empty: cnt_reg == '0, byte_count: cnt_reg,
                    line_state: line_reg};

  sequence s_single_write;
    ce && wr_event && !ctrl.demand_mode && state_reg == ST_REQ;
  endsequence

  // Checked at the pin, so the polarity path is covered as well
  a_req_blocked_rx: assert property (
    (ctrl.fifo_is_rx || status.fifo_full) |->
    dma_request != ctrl.req_active_high)
    else $error("request raised while FIFO full or receiving");

  a_single_req_drop: assert property (
    s_single_write |=> !req_active)
    else $error("single mode request not dropped after write");

  a_gap_holds_low: assert property (
    (state_reg == ST_GAP && gap_reg != '0) |-> !req_active ##1 !req_active)
    else $error("request returned during spacing gap");

  a_demand_final_stop: assert property (
    (ce && final_byte && !packet_sent) |=> pkt_ready_reg && !req_active)
    else $error("request kept after payload reached");

  a_force_pkt_ready: assert property (
    (ce && packet_ready_set) |=> status.packet_ready)
    else $error("forced packet ready not taken");

  a_dual_needs_cs: assert property (
    (ctrl.dual_address && !cs_sel) |-> !qual)
    else $error("dual mode write accepted without chip select and address");

  a_single_ack_qual: assert property (
    (!ctrl.dual_address && ctrl.dma_enable && !ctrl.fifo_is_rx &&
     !bus_s_reg.wr_n && ack_on) |-> qual)
    else $error("single mode write with acknowledge not accepted");

  a_line_diff_one: assert property (
    (ce && dp_s_reg && !dm_s_reg) |=> status.line_state == LINE_DIFF1)
    else $error("line pair decode wrong");

  a_req_polarity: assert property (
    (state_reg == ST_IDLE && !ctrl.req_active_high) |-> dma_request)
    else $error("idle request level wrong for active low");

endmodule

// ---- bench/bfd_dma_model.sv ----
module bfd_dma_model
  import bfd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic run,
  input wire logic bad_addr,
  input bfd_pkg::bfd_ctrl_t ctrl,
  input wire logic dma_request,
  output bfd_pkg::bfd_bus_t bus,
  output logic [15:0] wr_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] phase_reg = 4'h0;
  logic act;
  initial wr_cnt = 16'h0000;
  // recovery gap
  // Strobe low 4 cycles, high at least 5: covers 3 and 5 oscillator clocks
  always @(posedge sys_clk) begin
    if (phase_reg != 4'h0) begin
      phase_reg <= (phase_reg == 4'h8) ? 4'h0 : phase_reg + 4'h1;
    end else if (run && dma_request == ctrl.req_active_high) begin
      phase_reg <= 4'h1;
    end
    if (phase_reg == 4'h4) begin
      wr_cnt <= wr_cnt + 16'h0001;
    end
  end
  assign act = phase_reg != 4'h0 && phase_reg < 4'h5;
  // select lines
  // Released lines show the inverse, so stale values never match
  always_comb begin
    bus.wr_n = !act;
    bus.cs_n = !(act && ctrl.dual_address);
    // Bad-address runs also raise acknowledge, which dual mode must ignore
    bus.dma_acknowledge = (act && (!ctrl.dual_address || bad_addr)) ~^
      ctrl.ack_active_high;
    bus.address_lines = (act && ctrl.dual_address && !bad_addr) ?
      EP1_FIFO_ADDR : ~EP1_FIFO_ADDR;
    bus.data = {wr_cnt[7:0] ^ 8'hA5, wr_cnt[7:0]} ^ {16{!act}};
  end
endmodule

// ---- bench/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bfd_pkg::*;
  logic sys_clk = 0, rstn = 0, ps = 0, tx_read = 0, run = 0, bad = 0;
  logic dp = 0, dm = 0, prs = 0, dma_request;
  logic ce = 1;
  logic [7:0] tx_data;
  logic [15:0] wr_cnt, base;
  bfd_ctrl_t ctrl = '{ack_active_high: 1'b1, default: '0};
  bfd_bus_t bus;
  bfd_status_t st;
  int error_cnt = 0, total_checks = 0, cyc = 0, n;

  bfd_dma_write_port u_dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
    .ctrl(ctrl), .packet_ready_set(prs), .bus(bus), .usb_dp(dp),
    .usb_dm(dm), .tx_read(tx_read), .packet_sent(ps),
    .dma_request(dma_request), .tx_data(tx_data), .status(st));
  bfd_dma_model u_ctrl (.sys_clk(sys_clk), .run(run), .bad_addr(bad),
    .ctrl(ctrl), .dma_request(dma_request), .bus(bus), .wr_cnt(wr_cnt));

  initial forever #20 sys_clk = ~sys_clk;

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // A hang cuts the run short well above the expected length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict;
    end
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic rq(input logic on);
    return on ~^ ctrl.req_active_high;
  endfunction

  function automatic bfd_ctrl_t cfg(input logic dem, dual, w, rx, pol,
                                    input logic [7:0] sp,
                                    input logic [6:0] pl);
    return '{1'b1, dem, dual, w, rx, pol, ~pol, sp, pl};
  endfunction

  // Clears the FIFO, applies a setting and lets the controller run
  task automatic start(input bfd_ctrl_t c);
    @(posedge sys_clk);
    ctrl <= c;
    ps <= 1'b1;
    @(posedge sys_clk);
    ps <= 1'b0;
    run <= 1'b1;
    base = wr_cnt;
  endtask

  task automatic stop;
    run <= 1'b0;
    tick(10);
  endtask

  task automatic wait_w(input logic [15:0] t);
    while (wr_cnt !== t) tick(1);
  endtask

  task automatic drain(input int k, input logic w);
    logic [7:0] e;
    for (int i = 0; i < k; i++) begin
      e = 8'(w ? base + 16'(i / 2) : base + 16'(i));
      if (w && i[0]) e = e ^ 8'hA5;
      @(posedge sys_clk);
      tx_read <= 1'b1;
      @(posedge sys_clk);
      tx_read <= 1'b0;
      #1;
      chk("fifo data", e, tx_data);
    end
  endtask

  task automatic t_single;
    start(cfg(0, 0, 0, 0, 0, 8'h14, 7'h03));
    while (bus.wr_n !== 1'b0) tick(1);
    tick(5);
    chk("request after byte", rq(0), dma_request);
    for (n = 0; n < 100 && dma_request !== rq(1); n++) tick(1);
    chk("spacing window", 1, n >= 18 && n <= 28);
    wait_w(base + 16'h3);
    stop;
    chk("single count", 3, st.byte_count);
    drain(3, 0);
  endtask

  task automatic t_demand;
    start(cfg(1, 1, 1, 0, 0, 8'h00, 7'h06));
    wait_w(base + 16'h1);
    chk("demand request", rq(1), dma_request);
    wait_w(base + 16'h3);
    tick(6);
    chk("payload drop", rq(0), dma_request);
    chk("payload ready", 1, st.packet_ready);
    chk("dual count", 6, st.byte_count);
    stop;
    drain(6, 1);
  endtask

  task automatic t_bad_addr;
    bad <= 1'b1;
    start(cfg(0, 1, 0, 0, 0, 8'h00, 7'h03));
    tick(60);
    chk("wrong address", 0, st.byte_count);
    stop;
    bad <= 1'b0;
  endtask

  task automatic t_ready;
    start(cfg(1, 0, 0, 0, 1, 8'h00, 7'h40));
    wait_w(base + 16'h3);
    stop;
    chk("high polarity", rq(1), dma_request);
    @(posedge sys_clk);
    prs <= 1'b1;
    @(posedge sys_clk);
    prs <= 1'b0;
    tick(3);
    chk("forced ready", 1, st.packet_ready);
    chk("forced drop", rq(0), dma_request);
    chk("partial count", 3, st.byte_count);
  endtask

  task automatic t_rx_full;
    start(cfg(1, 0, 0, 1, 0, 8'h00, 7'h40));
    tick(40);
    chk("rx request", rq(0), dma_request);
    chk("rx count", 0, st.byte_count);
    chk("rx empty", 1, st.fifo_empty);
    stop;
    start(cfg(1, 0, 0, 0, 0, 8'h00, 7'h40));
    wait_w(base + 16'h40);
    tick(4);
    chk("full flag", 1, st.fifo_full);
    chk("full request", rq(0), dma_request);
    chk("full not empty", 0, st.fifo_empty);
    stop;
  endtask

  task automatic t_line;
    bfd_line_t exp_l[4] = '{LINE_SE0, LINE_DIFF0, LINE_DIFF1, LINE_UNDEF};
    for (int v = 0; v < 4; v++) begin
      @(posedge sys_clk);
      dp <= v[1];
      dm <= v[0];
      tick(5);
      chk("line state", exp_l[v], st.line_state);
    end
    // Low enable must freeze the synchroniser and the decode
    @(posedge sys_clk);
    ce <= 1'b0;
    dp <= 1'b0;
    dm <= 1'b1;
    tick(6);
    chk("frozen line", LINE_UNDEF, st.line_state);
    @(posedge sys_clk);
    ce <= 1'b1;
    tick(6);
    chk("thawed line", LINE_DIFF0, st.line_state);
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    tick(1);
    chk("reset request", 1, dma_request);
    chk("reset count", 0, st.byte_count);
    t_single;
    t_demand;
    t_bad_addr;
    t_ready;
    t_rx_full;
    t_line;
    give_verdict;
  end
endmodule
